/* File: fws_pkg.sv */
// Constants, types and pin bundles for the flash status polling controller
//
// Summary of operation
// - Read status twice, compare toggle bit first.
// - Still toggling: check timing limit, recheck toggling.
// - Toggling after timing limit: fail, write reset.
// - Resumed polling restarts from the first read.
// - Toggle reads never interleave with other sectors.
// - After timing limit, reset command restores reads.
// - Check erase timeout indicator around added erases.
// - Skip indicator checks only with tight spacing.
// - Buffer abort flag needs abort reset sequence.
// - Status reads use a valid operation address.
// - Buffered programming polls last loaded address.
package fws_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;

  // ==========================================================================
  // Timing at a 20 MHz core clock
  localparam int CLK_NS      = 50;
  localparam int ACCESS_NS   = 100;
  localparam int WE_PULSE_NS = 100;
  localparam int RECOVER_NS  = 50;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] RD_CYC  = 4'((ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [3:0] WE_CYC  = 4'((WE_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] REC_CYC = 4'((RECOVER_NS + CLK_NS - 1) / CLK_NS);

  // ==========================================================================
  // Status word bit positions
  localparam int BIT_DATA_POLL      = 7;
  localparam int BIT_FIRST_TOGGLE   = 6;
  localparam int BIT_TIMING_LIMIT   = 5;
  localparam int BIT_ERASE_TIMEOUT  = 3;
  localparam int BIT_SECTOR_TOGGLE  = 2;
  localparam int BIT_BUFFER_ABORT   = 1;

  // ==========================================================================
  // Flash commands
  localparam logic [ADDR_W-1:0] CMD_UNLOCK1_ADDR = 26'h0000555;
  localparam logic [ADDR_W-1:0] CMD_UNLOCK2_ADDR = 26'h00002AA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK1_DATA = 16'h00AA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2_DATA = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_RESET        = 16'h00F0;

  // ==========================================================================
  // Controller registers (word index on regAddr)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA  = 4'h4;

  localparam int CTRL_GO     = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_EXPECT = 3;
  localparam int CTRL_STOP   = 4;
  localparam int CTRL_SECSEL = 5;

  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_FAIL     = 2;
  localparam int ST_ABORT    = 3;
  localparam int ST_READY    = 4;
  localparam int ST_ERASING  = 5;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    OP_READ     = 2'h0,
    OP_WRITE    = 2'h1,
    OP_TOGGLE   = 2'h2,
    OP_DATAPOLL = 2'h3
  } fws_op_t;

  typedef enum logic [2:0] {
    C_IDLE    = 3'b001,
    C_STROBE  = 3'b010,
    C_RECOVER = 3'b100
  } fws_cyc_state_t;

  typedef enum logic [6:0] {
    S_IDLE    = 7'b0000001,
    S_SINGLE  = 7'b0000010,
    S_FIRST   = 7'b0000100,
    S_SECOND  = 7'b0001000,
    S_RECHK1  = 7'b0010000,
    S_RECHK2  = 7'b0100000,
    S_RECOVER = 7'b1000000
  } fws_state_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fws_cyc_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dqOut;
    logic              dqOe;
    logic              ceN;
    logic              oeN;
    logic              weN;
  } fws_pins_t;

endpackage : fws_pkg

/* File: fws_bus_cycle.sv */
// One read or write cycle on the parallel flash pins
`timescale 1ns/1ns
module fws_bus_cycle
  import fws_pkg::*;
(
  input  wire logic         core_clk, // 20 MHz clock
  input  wire logic         resetn,   // Async reset, active low
  input  wire logic         req,      // Start a cycle, only while idle
  input  wire fws_cyc_req_t reqInfo,  // Kind, address and write data
  output logic              done,     // One-cycle pulse at cycle end
  output logic [DATA_W-1:0] rdata,    // Data of the last read
  output fws_pins_t         pins,     // Flash pin drive
  input  wire logic [DATA_W-1:0] dqIn // Flash data bus level
);

  fws_cyc_state_t    state;
  logic [3:0]        cnt;
  logic              isWrite;
  logic [DATA_W-1:0] dqMeta;
  logic [DATA_W-1:0] dqSync;

  // ==========================================================================
  // Pin input synchroniser
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dqMeta <= '0;
      dqSync <= '0;
    end else begin
      dqMeta <= dqIn;
      dqSync <= dqMeta;
    end
  end

  // ==========================================================================
  // Sequencing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state   <= C_IDLE;
      cnt     <= '0;
      isWrite <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        C_IDLE: begin
          if (req) begin
            state   <= C_STROBE;
            isWrite <= reqInfo.write;
            cnt     <= reqInfo.write ? WE_CYC - 4'h1 : RD_CYC - 4'h1;
          end
        end
        C_STROBE: begin
          if (cnt == 4'h0) begin
            state <= C_RECOVER;
            cnt   <= REC_CYC - 4'h1;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        C_RECOVER: begin
          if (cnt == 4'h0) begin
            state <= C_IDLE;
            done  <= 1'b1;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: state <= C_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Pin drive; strobes rise between cycles so each read is a fresh one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pins.addr  <= '0;
      pins.dqOut <= '0;
      pins.dqOe  <= 1'b0;
      pins.ceN   <= 1'b1;
      pins.oeN   <= 1'b1;
      pins.weN   <= 1'b1;
    end else if (state == C_IDLE && req) begin
      pins.addr  <= reqInfo.addr;
      pins.dqOut <= reqInfo.data;
      pins.dqOe  <= reqInfo.write;
      pins.ceN   <= 1'b0;
      pins.oeN   <= reqInfo.write;
      pins.weN   <= !reqInfo.write;
    end else if (state == C_STROBE && cnt == 4'h0) begin
      pins.ceN <= 1'b1;
      pins.oeN <= 1'b1;
      pins.weN <= 1'b1;
    end else if (state == C_RECOVER && cnt == 4'h0) begin
      pins.dqOe <= 1'b0;
    end
  end

  // Sampled as the strobe ends, after access time plus synchroniser lag
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (state == C_STROBE && cnt == 4'h0 && !isWrite) begin
      rdata <= dqSync;
    end
  end

  // ==========================================================================
  // Checks
  property p_weWidth;
    @(posedge core_clk) disable iff (!resetn)
      $fell(pins.weN) |-> (!pins.weN && pins.dqOe)[*2] ##1 pins.weN;
  endproperty
  a_weWidth: assert property (p_weWidth) else $error("write strobe width wrong");

  property p_strobeGap;
    @(posedge core_clk) disable iff (!resetn)
      done |-> pins.ceN && pins.oeN && pins.weN;
  endproperty
  a_strobeGap: assert property (p_strobeGap) else $error("strobes not released between cycles");

endmodule : fws_bus_cycle

/* File: fws_host.sv */
// Host controller that polls flash write and erase status
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module fws_host
  import fws_pkg::*;
(
  input  wire logic              core_clk,     // 20 MHz clock
  input  wire logic              resetn,       // Async reset, active low
  input  wire logic [3:0]        regAddr,      // Register word index
  input  wire logic [31:0]       regWdata,     // Register write data
  input  wire logic              regWr,        // Write strobe
  input  wire logic              regRd,        // Read strobe
  output logic [31:0]            regRdata,     // Read data, cycle after strobe
  output fws_pins_t              flPins,       // Flash pin drive
  input  wire logic [DATA_W-1:0] flDqIn,       // Flash data bus level
  input  wire logic              readyBusyN    // Flash ready, low while busy
);

  fws_state_t        state;
  fws_op_t           op;
  fws_cyc_req_t      cycInfo;
  logic              cycReq;
  logic              cycDone;
  logic [DATA_W-1:0] lastData;
  logic [DATA_W-1:0] prev;
  logic [ADDR_W-1:0] pollAddr;
  logic [DATA_W-1:0] wrData;
  logic              expectBit;
  logic              sectorSel;
  logic              doneFlag;
  logic              failFlag;
  logic              abortFlag;
  logic              stopReq;
  logic [1:0]        step;
  logic              rdyMeta;
  logic              rdySync;
  logic              ctrlWr;
  logic              go;
  fws_op_t           goOp;
  logic              toggled;
  logic              stillBusy;
  logic [1:0]        pollReads;

  // ==========================================================================
  // Cycle engine
  fws_bus_cycle u_cycle (
    .core_clk (core_clk),
    .resetn   (resetn),
    .req      (cycReq),
    .reqInfo  (cycInfo),
    .done     (cycDone),
    .rdata    (lastData),
    .pins     (flPins),
    .dqIn     (flDqIn)
  );

  // ==========================================================================
  // Decode
  assign ctrlWr = regWr && regAddr == REG_CTRL;
  assign go     = ctrlWr && regWdata[CTRL_GO] && state == S_IDLE;
  assign goOp   = fws_op_t'(regWdata[CTRL_OP_LSB +: 2]);

  // Sector toggle bit tells which sectors erase, first toggle bit whether busy
  always_comb begin
    if (sectorSel) begin
      toggled = lastData[BIT_SECTOR_TOGGLE] ^ prev[BIT_SECTOR_TOGGLE];
    end else begin
      toggled = lastData[BIT_FIRST_TOGGLE] ^ prev[BIT_FIRST_TOGGLE];
    end
    if (op == OP_DATAPOLL) begin
      stillBusy = lastData[BIT_DATA_POLL] != expectBit;
    end else begin
      stillBusy = toggled;
    end
  end

  // Reset sequences: plain reset after a timeout, unlocked one after abort
  function automatic fws_cyc_req_t recoverCmd(input logic [1:0] idx, input logic isAbort);
    fws_cyc_req_t r;
    r.write = 1'b1;
    r.addr  = CMD_UNLOCK1_ADDR;
    r.data  = CMD_RESET;
    if (isAbort && idx == 2'h0) begin
      r.data = CMD_UNLOCK1_DATA;
    end else if (isAbort && idx == 2'h1) begin
      r.addr = CMD_UNLOCK2_ADDR;
      r.data = CMD_UNLOCK2_DATA;
    end
    return r;
  endfunction : recoverCmd

  // ==========================================================================
  // Software settings; address frozen while an operation runs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pollAddr <= '0;
      wrData   <= '0;
    end else if (regWr && state == S_IDLE) begin
      if (regAddr == REG_ADDR) begin
        pollAddr <= regWdata[ADDR_W-1:0];
      end
      if (regAddr == REG_WDATA) begin
        wrData <= regWdata[DATA_W-1:0];
      end
    end
  end

  // Leaving the poll early; the next start begins from a first read
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stopReq <= 1'b0;
    end else if (ctrlWr && regWdata[CTRL_STOP] && state != S_IDLE) begin
      stopReq <= 1'b1;
    end else if (state == S_IDLE) begin
      stopReq <= 1'b0;
    end
  end

  // ==========================================================================
  // Sequencer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= S_IDLE;
      op        <= OP_READ;
      expectBit <= 1'b0;
      sectorSel <= 1'b0;
      cycReq    <= 1'b0;
      cycInfo   <= '0;
      prev      <= '0;
      step      <= '0;
      doneFlag  <= 1'b0;
      failFlag  <= 1'b0;
      abortFlag <= 1'b0;
    end else begin
      cycReq <= 1'b0;
      case (state)
        S_IDLE: begin
          if (go) begin
            doneFlag  <= 1'b0;
            failFlag  <= 1'b0;
            abortFlag <= 1'b0;
            op        <= goOp;
            expectBit <= regWdata[CTRL_EXPECT];
            sectorSel <= regWdata[CTRL_SECSEL];
            cycReq    <= 1'b1;
            cycInfo   <= '{write: goOp == OP_WRITE, addr: pollAddr, data: wrData};
            state     <= (goOp == OP_READ || goOp == OP_WRITE) ? S_SINGLE : S_FIRST;
          end
        end
        S_SINGLE: begin
          if (cycDone) begin
            doneFlag <= 1'b1;
            state    <= S_IDLE;
          end
        end
        S_FIRST: begin
          if (cycDone) begin
            prev <= lastData;
            if (stopReq) begin
              state <= S_IDLE;
            end else begin
              cycReq        <= 1'b1;
              cycInfo.write <= 1'b0;
              state         <= S_SECOND;
            end
          end
        end
        S_SECOND: begin
          if (cycDone) begin
            prev <= lastData;
            if (stillBusy && lastData[BIT_BUFFER_ABORT]) begin
              abortFlag <= 1'b1;
              step      <= 2'h0;
              cycReq    <= 1'b1;
              cycInfo   <= recoverCmd(2'h0, 1'b1);
              state     <= S_RECOVER;
            end else if (!stillBusy) begin
              doneFlag <= 1'b1;
              state    <= S_IDLE;
            end else if (lastData[BIT_TIMING_LIMIT]) begin
              cycReq <= 1'b1;
              state  <= S_RECHK1;
            end else if (stopReq) begin
              state <= S_IDLE;
            end else begin
              cycReq <= 1'b1;
            end
          end
        end
        S_RECHK1: begin
          if (cycDone) begin
            prev   <= lastData;
            cycReq <= 1'b1;
            state  <= S_RECHK2;
          end
        end
        S_RECHK2: begin
          if (cycDone) begin
            if (stillBusy) begin
              failFlag <= 1'b1;
              step     <= 2'h0;
              cycReq   <= 1'b1;
              cycInfo  <= recoverCmd(2'h0, 1'b0);
              state    <= S_RECOVER;
            end else begin
              doneFlag <= 1'b1;
              state    <= S_IDLE;
            end
          end
        end
        S_RECOVER: begin
          if (cycDone) begin
            if (abortFlag && step != 2'h2) begin
              step    <= step + 2'h1;
              cycReq  <= 1'b1;
              cycInfo <= recoverCmd(step + 2'h1, 1'b1);
            end else begin
              doneFlag <= 1'b1;
              state    <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Ready pin synchroniser and register reads
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdyMeta <= 1'b0;
      rdySync <= 1'b0;
    end else begin
      rdyMeta <= readyBusyN;
      rdySync <= rdyMeta;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= '0;
    end else if (regRd) begin
      case (regAddr)
        REG_ADDR:   regRdata <= 32'(pollAddr);
        REG_WDATA:  regRdata <= 32'(wrData);
        REG_RDATA:  regRdata <= 32'(lastData);
        REG_STATUS: begin
          regRdata              <= '0;
          regRdata[ST_BUSY]     <= state != S_IDLE;
          regRdata[ST_DONE]     <= doneFlag;
          regRdata[ST_FAIL]     <= failFlag;
          regRdata[ST_ABORT]    <= abortFlag;
          regRdata[ST_READY]    <= rdySync;
          regRdata[ST_ERASING]  <= lastData[BIT_ERASE_TIMEOUT];
        end
        default:    regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // ==========================================================================
  // Checks
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pollReads <= '0;
    end else if (go) begin
      pollReads <= '0;
    end else if (cycDone && (state == S_FIRST || state == S_SECOND) && pollReads != 2'h3) begin
      pollReads <= pollReads + 2'h1;
    end
  end

  property p_twoReads;
    @(posedge core_clk) disable iff (!resetn)
      $rose(doneFlag) && !failFlag && !abortFlag && (op == OP_TOGGLE || op == OP_DATAPOLL)
        |-> pollReads >= 2'h2;
  endproperty
  a_twoReads: assert property (p_twoReads) else $error("poll finished before two reads");

  property p_recheck;
    @(posedge core_clk) disable iff (!resetn)
      state == S_RECHK1 && $past(state) == S_SECOND |-> lastData[BIT_TIMING_LIMIT];
  endproperty
  a_recheck: assert property (p_recheck) else $error("recheck without timing limit");

  property p_failReset;
    @(posedge core_clk) disable iff (!resetn)
      state == S_RECOVER && cycReq && !abortFlag |-> cycInfo.write && cycInfo.data == CMD_RESET;
  endproperty
  a_failReset: assert property (p_failReset) else $error("fail path not writing reset");

  property p_restart;
    @(posedge core_clk) disable iff (!resetn)
      go && (goOp == OP_TOGGLE || goOp == OP_DATAPOLL) |=> state == S_FIRST && cycReq;
  endproperty
  a_restart: assert property (p_restart) else $error("poll did not restart at first read");

  property p_sameAddr;
    @(posedge core_clk) disable iff (!resetn)
      cycReq && !cycInfo.write && state != S_SINGLE |-> cycInfo.addr == pollAddr;
  endproperty
  a_sameAddr: assert property (p_sameAddr) else $error("status read moved to other address");

  property p_failRecover;
    @(posedge core_clk) disable iff (!resetn)
      $rose(failFlag) |-> state == S_RECOVER ##[1:20] (state == S_IDLE && doneFlag);
  endproperty
  a_failRecover: assert property (p_failRecover) else $error("reset after timeout not completed");

  property p_abortSeq;
    @(posedge core_clk) disable iff (!resetn)
      $rose(abortFlag) |-> state == S_RECOVER && cycInfo.data == CMD_UNLOCK1_DATA
        ##[1:60] (state == S_IDLE && doneFlag);
  endproperty
  a_abortSeq: assert property (p_abortSeq) else $error("abort reset sequence wrong");

  property p_busyRead;
    @(posedge core_clk) disable iff (!resetn)
      state == S_SECOND && cycDone && !stillBusy |=> state == S_IDLE && doneFlag;
  endproperty
  a_busyRead: assert property (p_busyRead) else $error("completion not reported");

endmodule : fws_host

/* File: fws_flash_model.sv */
// Behavioural flash device for the polling bench
`timescale 1ns/1ns
module fws_flash_model
  import fws_pkg::*;
(
  input  wire fws_pins_t    pins,      // Host pin drive
  output logic [DATA_W-1:0] dq,        // Device drive
  output logic              readyBusyN // Low while busy
);
  int armLen, armWin, left, win, dly;
  bit eA, tA, aA, erase, tlim, abt, busy, tg, ok;
  logic [DATA_W-1:0] d1, d2;
  assign readyBusyN = ~busy;
  task automatic arm(int n, int w, bit e, bit t, bit a, int d);
    armLen = n;
    armWin = w;
    eA = e;
    tA = t;
    aA = a;
    dly = d;
  endtask : arm
  initial begin
    busy = 0;
    dq = '0;
    // Nonzero so the address has settled before the answer
    dly = 10;
  end
  // ==========
  // Reads, answered dly ns after the strobe
  always @(negedge pins.oeN) begin
    #(dly);
    if (busy) begin
      dq = {9'h000, tg, tlim, 1'b0, erase && win == 0, erase & tg, abt, 1'b0};
      tg = ~tg;
      if (win > 0) win--;
      if (left > 0) left--;
      if (left == 0) busy = 0;
    end else begin
      dq = {pins.addr[7:0], 8'h84};
    end
  end
  // Released bus must not keep stale data
  always @(posedge pins.oeN) dq = ~dq;
  // ==========
  // Writes
  always @(posedge pins.weN) begin
    ok = abt ? d2 == CMD_UNLOCK1_DATA && d1 == CMD_UNLOCK2_DATA : tlim;
    if (!busy && armLen != 0) begin
      busy = 1;
      left = armLen;
      win = armWin;
      erase = eA;
      tlim = tA;
      abt = aA;
      tg = 0;
      armLen = 0;
    end else if (busy && erase && win > 0 && pins.dqOut == 16'h0030) begin
      win = armWin;
    end else if (busy && pins.dqOut == CMD_RESET && ok) begin
      busy = 0;
    end
    d2 = d1;
    d1 = pins.dqOut;
  end
endmodule : fws_flash_model

/* File: fws_host_tb.sv */
// Self-checking bench for the flash status polling host
`timescale 1ns/1ns
module fws_host_tb
  import fws_pkg::*;
;
  logic              core_clk, resetn, regWr, regRd, readyBusyN;
  logic [3:0]        regAddr;
  logic [31:0]       regWdata, regRdata, st;
  logic [DATA_W-1:0] fDq, dqBus;
  fws_pins_t         flPins;
  int                fails, n_checks;
  assign dqBus = flPins.dqOe ? flPins.dqOut : fDq;
  fws_host i_dut (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .flPins(flPins), .flDqIn(dqBus),
    .readyBusyN(readyBusyN));
  fws_flash_model i_flash (.pins(flPins), .dq(fDq), .readyBusyN(readyBusyN));
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  // ==========
  // Bus tasks
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // Done and idle both needed: busy may rise a cycle late; a stop only waits for idle
  task automatic go(logic [31:0] c);
    int i;
    wr(REG_CTRL, c);
    for (i = 0; i < 4000; i++) begin
      rd(REG_STATUS, st);
      if (st[ST_BUSY] === 1'b0 && (st[ST_DONE] === 1'b1 || c[CTRL_STOP])) break;
    end
    if (i == 4000) begin
      fails++;
      end_of_test();
    end
  endtask : go
  task automatic sread(logic [ADDR_W-1:0] a, logic [15:0] e);
    wr(REG_ADDR, 32'(a));
    go(32'h1);
    rd(REG_RDATA, st);
    cmp(st, 32'(e));
  endtask : sread
  task automatic swrite(logic [ADDR_W-1:0] a);
    wr(REG_ADDR, 32'(a));
    wr(REG_WDATA, 32'h30);
    go(32'h3);
  endtask : swrite
  // ==========
  // Main sequence
  initial begin
    logic [ADDR_W-1:0] a;
    int tg, w, left;
    int lens[6] = '{0, 4, -1, 3, -1, 4};
    logic [31:0] ctls[6] = '{32'h5, 32'h25, 32'h5, 32'h5, 32'h5, 32'hF};
    logic [31:0] exps[6] = '{32'h12, 32'h12, 32'h16, 32'h12, 32'h1A, 32'h12};
    bit [5:0] ers = 6'h22;
    bit [5:0] tls = 6'h0C;
    regAddr = '0;
    regWdata = '0;
    regWr = 0;
    regRd = 0;
    resetn = 0;
    fails = 0;
    n_checks = 0;
    void'($urandom(32'h4BDD));
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      a = ADDR_W'($urandom);
      sread(a, {a[7:0], 8'h84});
    end
    rd(4'hF, st);
    cmp(st, 32'h0);
    $display("Test idle reads done");
    a = ADDR_W'($urandom);
    i_flash.arm(7, 3, 1, 0, 0, 80);
    swrite(a);
    tg = 0;
    w = 3;
    left = 7;
    for (int i = 0; i < 9; i++) begin
      if (left > 0) begin
        sread(a, (tg ? 16'h0044 : 16'h0000) | (w == 0 ? 16'h0008 : 16'h0000));
        tg ^= 1;
        if (w > 0) w--;
        left--;
      end else begin
        sread(a, {a[7:0], 8'h84});
      end
      if (i == 1 || i == 5) begin
        swrite(a);
        if (left > 0 && w > 0) w = 3;
      end
    end
    $display("Test erase status reads done");
    for (int k = 0; k < 6; k++) begin
      a = ADDR_W'($urandom);
      i_flash.arm(k == 0 ? 3 + int'($urandom % 8) : lens[k], 1, ers[k], tls[k], k == 4, 10 + int'($urandom % 70));
      swrite(a);
      go(ctls[k]);
      rd(REG_STATUS, st);
      cmp(st, exps[k]);
      sread(a, {a[7:0], 8'h84});
      $display("Test poll case %0d done", k);
    end
    a = ADDR_W'($urandom);
    i_flash.arm(40, 0, 1, 0, 0, 50);
    swrite(a);
    wr(REG_CTRL, 32'h5);
    go(32'h10);
    rd(REG_STATUS, st);
    cmp(st, 32'h20);
    go(32'h5);
    rd(REG_STATUS, st);
    cmp(st, 32'h12);
    sread(a, {a[7:0], 8'h84});
    $display("Test stop and restart done");
    end_of_test();
  end
endmodule : fws_host_tb
